//--- core/event_counter_pkg.sv
// Package for the edge or cycle event counter: register map, field layout,
// reset values and timing counts.
// Assumes a 32-bit AHB-Lite register bus and a single 250 MHz clock.
package event_counter_pkg;

	// Register byte offsets inside the 256-byte window selected by hsel.
	localparam logic [7:0] OFFSET_COUNTER_VALUE = 8'h00; // Counter value, read and write.
	localparam logic [7:0] OFFSET_CONTROL       = 8'h04; // Counter control register.
	localparam logic [7:0] OFFSET_IRQ_STATUS    = 8'h08; // Sticky status, read only.
	localparam logic [7:0] OFFSET_IRQ_CLEAR     = 8'h0C; // Write one to clear, reads zero.
	localparam logic [7:0] OFFSET_IRQ_ENABLE    = 8'h10; // Interrupt enable.

	// Widths of the stored registers.
	localparam int COUNTER_WIDTH = 8;
	localparam int CONTROL_WIDTH = 6;
	localparam int RATE_WIDTH    = 3;
	localparam int IRQ_WIDTH     = 1;

	// Field positions inside the control register.
	localparam int CTRL_RATE_LSB   = 0; // Prescaler ratio select, three bits.
	localparam int CTRL_ASSIGN_BIT = 3; // Prescaler assign bit, zero routes the prescaler here.
	localparam int CTRL_EDGE_BIT   = 4; // Count edge select, zero rising, one falling.
	localparam int CTRL_SOURCE_BIT = 5; // Count source, zero cycle clock, one pin edge.

	// Field position inside the status, clear and enable registers.
	localparam int IRQ_OVERFLOW_BIT = 0;

	// Reset values.
	localparam logic [COUNTER_WIDTH-1:0] COUNTER_RESET = 8'h00;
	localparam logic [CONTROL_WIDTH-1:0] CONTROL_RESET = 6'h00;
	localparam logic [IRQ_WIDTH-1:0]     IRQ_RESET     = 1'h0;
	localparam logic [31:0]              RDATA_RESET   = 32'h00000000;

	// Timing: the bus clock period and the instruction cycle of two clocks.
	localparam int CLOCK_PERIOD_NS  = 4;
	localparam int INSN_CYCLE_NS    = 8;
	localparam int INSN_CYCLE_CLKS  = INSN_CYCLE_NS / CLOCK_PERIOD_NS;
	localparam int INSN_DIV_WIDTH   = 4;

	// AHB transfer type and response codes.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage : event_counter_pkg

//--- core/event_prescaler.sv
// Shared prescaler: divides a tick stream by two to the power (rate + 1).
// Assumes tick and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module event_prescaler
	import event_counter_pkg::*;
(
	input  wire logic                  hclk,      // Bus clock.
	input  wire logic                  hresetn,   // Asynchronous reset, active low.
	input  wire logic                  tick,      // One pulse per source event.
	input  wire logic                  clear,     // Clears the internal count.
	input  wire logic [RATE_WIDTH-1:0] rate,      // Ratio select, 0 gives 1:2, 7 gives 1:256.
	output logic                       out_tick   // One pulse per divided event.
);

	// Internal count of source events since the last clear or reset.
	logic [COUNTER_WIDTH-1:0] count;
	// Low bits of the count that must all be set before a pulse leaves.
	logic [COUNTER_WIDTH-1:0] mask;

	// The mask holds rate + 1 ones in its low bits.
	assign mask = COUNTER_WIDTH'((9'h002 << rate) - 9'h001);

	// A pulse leaves on the source event that completes a full ratio.
	assign out_tick = tick && !clear && ((count | ~mask) == 8'hFF);

	// Reset and the clear input empty the count; a tick advances it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= COUNTER_RESET;
		end else if (clear) begin
			// A counter write empties the prescaler.
			count <= COUNTER_RESET;
		end else if (tick) begin
			// Bits above the mask wrap harmlessly.
			count <= count + 8'h01;
		end
	end

endmodule : event_prescaler

`default_nettype wire

//--- core/event_counter_top.sv
// Edge or cycle event counter with an AHB-Lite register slave and an
// overflow interrupt.
// Assumes one 250 MHz clock; the counter pin is asynchronous to it.
//
// How it works
// - pin edges count, edge chosen by bit four.
// - internal mode counts instruction cycle clock ticks.
// - software reads and writes the counter value.
// - prescaler assign bit clear routes the prescaler.
// - only counter writes clear the prescaler count.
// - eight bit counter wraps to zero on overflow.
// - overflow sets sticky flag until software clears.
`timescale 1ns/100ps
`default_nettype none

module event_counter_top
	import event_counter_pkg::*;
(
	input  wire logic        hclk,        // Bus clock, 250 MHz.
	input  wire logic        hresetn,     // Asynchronous reset, active low.
	input  wire logic        hsel,        // Slave select.
	input  wire logic [31:0] haddr,       // Byte address.
	input  wire logic [1:0]  htrans,      // Transfer type.
	input  wire logic        hwrite,      // Write when high.
	input  wire logic [2:0]  hsize,       // Transfer size, whole words only.
	input  wire logic [31:0] hwdata,      // Write data, valid in the data phase.
	input  wire logic        hready,      // Bus ready from the interconnect.
	output logic             hreadyout,   // Slave ready, never stretched.
	output logic             hresp,       // Response, always OKAY.
	output logic [31:0]      hrdata,      // Read data from a flip-flop.
	input  wire logic        counter_pin, // External pulse source, asynchronous.
	output logic             irq          // Level interrupt request.
);

	// Address phase captured for the following data phase.
	logic                       data_write;     // A write data phase is in progress.
	logic [7:0]                 data_offset;    // Offset of the pending write.
	logic                       addr_accept;    // An address phase is taken this edge.

	// Stored registers.
	logic [COUNTER_WIDTH-1:0]   event_counter_value;        // The counter itself.
	logic [CONTROL_WIDTH-1:0]   counter_control_register;   // Mode and prescaler control.
	logic [IRQ_WIDTH-1:0]       interrupt_status_register;  // Sticky event flags.
	logic [IRQ_WIDTH-1:0]       interrupt_enable;           // Interrupt enables.

	// Decoded write strobes in the data phase.
	logic                       write_counter;  // Software writes the counter.
	logic                       write_control;  // Software writes the control register.
	logic                       write_clear;    // Software writes the clear register.
	logic                       write_enable;   // Software writes the enable register.

	// Pin synchroniser and edge detection.
	logic                       pin_meta;       // First synchroniser stage.
	logic                       pin_sync;       // Second synchroniser stage.
	logic                       pin_prev;       // Previous synchronised level.
	logic                       pin_edge;       // Selected edge seen on the pin.

	// Count sources.
	logic [INSN_DIV_WIDTH-1:0]  insn_div;       // Instruction cycle divider.
	logic                       insn_tick;      // One pulse per instruction cycle.
	logic                       source_tick;    // Event from the selected source.
	logic                       presc_tick;     // Event after the prescaler.
	logic                       count_tick;     // Event that advances the counter.
	logic                       overflow;       // Counter wraps this cycle.

	// Control fields.
	logic                       count_edge_select;      // Zero rising, one falling.
	logic                       prescaler_assign_bit;   // Zero routes the prescaler here.
	logic                       source_is_pin;          // One counts pin edges.
	logic [RATE_WIDTH-1:0]      presc_rate;             // Prescaler ratio select.

	assign count_edge_select    = counter_control_register[CTRL_EDGE_BIT];
	assign prescaler_assign_bit = counter_control_register[CTRL_ASSIGN_BIT];
	assign source_is_pin        = counter_control_register[CTRL_SOURCE_BIT];
	assign presc_rate           = counter_control_register[CTRL_RATE_LSB +: RATE_WIDTH];

	// The slave never inserts wait states and always answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;

	// An address phase counts only when selected, non-idle and the bus is ready.
	assign addr_accept = hsel && htrans[1] && hready;

	// Write strobes act in the data phase, when hwdata stands.
	assign write_counter = data_write && (data_offset == OFFSET_COUNTER_VALUE);
	assign write_control = data_write && (data_offset == OFFSET_CONTROL);
	assign write_clear   = data_write && (data_offset == OFFSET_IRQ_CLEAR);
	assign write_enable  = data_write && (data_offset == OFFSET_IRQ_ENABLE);

	// Capture the address phase of a write for use in its data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_write  <= 1'b0;
			data_offset <= 8'h00;
		end else if (addr_accept) begin
			// The low two offset bits are dropped, so unaligned offsets decode as their word.
			data_write  <= hwrite;
			data_offset <= {haddr[7:2], 2'b00};
		end else begin
			data_write  <= 1'b0;
		end
	end

	// Read data is sampled at the address phase edge and stands in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= RDATA_RESET;
		end else if (addr_accept && !hwrite) begin
			// Byte lanes are ignored, as for writes, so the read decode matches the write decode.
			case ({haddr[7:2], 2'b00})
				// The counter reads back as an ordinary register.
				OFFSET_COUNTER_VALUE: hrdata <= {24'h000000, event_counter_value};
				OFFSET_CONTROL:       hrdata <= {26'h0000000, counter_control_register};
				OFFSET_IRQ_STATUS:    hrdata <= {31'h00000000, interrupt_status_register};
				OFFSET_IRQ_ENABLE:    hrdata <= {31'h00000000, interrupt_enable};
				// Clear register and unmapped offsets read as zero.
				default:              hrdata <= RDATA_RESET;
			endcase
		end else begin
			hrdata <= RDATA_RESET;
		end
	end

	// Control register written by software.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_control_register <= CONTROL_RESET;
		end else if (write_control) begin
			counter_control_register <= hwdata[CONTROL_WIDTH-1:0];
		end
	end

	// Interrupt enable register written by software.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interrupt_enable <= IRQ_RESET;
		end else if (write_enable) begin
			interrupt_enable <= hwdata[IRQ_WIDTH-1:0];
		end
	end

	// Two flip-flops bring the pin into the clock domain; a third keeps history.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= counter_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// The edge select bit picks a rising or a falling edge.
	assign pin_edge = count_edge_select ? (pin_prev && !pin_sync)
	                                    : (!pin_prev && pin_sync);

	// The instruction cycle is two bus clocks; this divider marks each one.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			insn_div <= '0;
		end else if (insn_tick) begin
			insn_div <= '0;
		end else begin
			insn_div <= insn_div + 4'h1;
		end
	end

	assign insn_tick = (insn_div == INSN_DIV_WIDTH'(INSN_CYCLE_CLKS - 1));

	// Only the selected source feeds the counter path.
	// Pin edges in external mode, instruction cycles otherwise.
	assign source_tick = source_is_pin ? pin_edge : insn_tick;

	// Shared prescaler, emptied by every counter write.
	event_prescaler u_prescaler (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.tick     (source_tick),
		.clear    (write_counter),
		.rate     (presc_rate),
		.out_tick (presc_tick)
	);

	// The prescaler feeds the counter only while the assign bit is clear.
	assign count_tick = prescaler_assign_bit ? source_tick : presc_tick;

	// Overflow is the wrap from the maximum value back to zero.
	assign overflow = count_tick && !write_counter && (event_counter_value == 8'hFF);

	// The counter: a software write wins over a count event in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_counter_value <= COUNTER_RESET;
		end else if (write_counter) begin
			// Software loads a new value.
			event_counter_value <= hwdata[COUNTER_WIDTH-1:0];
		end else if (count_tick) begin
			// Eight bits wrap naturally from FF to 00.
			event_counter_value <= event_counter_value + 8'h01;
		end
	end

	// Sticky overflow flag: a new overflow wins over a clear in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interrupt_status_register <= IRQ_RESET;
		end else if (overflow) begin
			// Each wrap sets the flag.
			interrupt_status_register[IRQ_OVERFLOW_BIT] <= 1'b1;
		end else if (write_clear && hwdata[IRQ_OVERFLOW_BIT]) begin
			// Writing one to the clear register drops the flag.
			interrupt_status_register[IRQ_OVERFLOW_BIT] <= 1'b0;
		end
	end

	// The interrupt is high while any enabled flag is set.
	assign irq = |(interrupt_status_register & interrupt_enable);

endmodule : event_counter_top

`default_nettype wire

//--- tb/event_counter_checker.sv
// Checker: bus answers and register readback of the event counter.
// Bound to event_counter_top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module event_counter_checker
	import event_counter_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        irq
);
	logic       take; // A transfer is accepted at this edge.
	logic       rd_q; // A read is in its data phase.
	logic       wr_q; // A write is in its data phase.
	logic [7:0] ad_q; // Offset of the transfer in its data phase.
	assign take = hsel & htrans[1] & hready;
	// Remembers the address phase so that the data phase can be judged.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			ad_q <= 8'h00;
		end else begin
			rd_q <= take & !hwrite;
			wr_q <= take & hwrite;
			ad_q <= haddr[7:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("response is not okay");
	a_ready_high: assert property (hreadyout)
		else $error("slave stretched a transfer");
	a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h00000000)
		else $error("read data outside a read");
	a_unmapped_zero: assert property (
		rd_q && ad_q[7:2] > OFFSET_IRQ_ENABLE[7:2] |-> hrdata == 32'h00000000)
		else $error("unmapped offset read nonzero");
	a_ctrl_upper: assert property (rd_q && ad_q[7:2] == OFFSET_CONTROL[7:2] |-> hrdata[31:6] == 26'h0)
		else $error("control upper bits not zero");
	a_status_flag: assert property (
		rd_q && ad_q[7:2] == OFFSET_IRQ_STATUS[7:2] && $past(irq) |-> hrdata == 32'h00000001)
		else $error("status read disagrees with interrupt");
	a_ctrl_readback: assert property (
		wr_q && ad_q[7:2] == OFFSET_CONTROL[7:2] ##2
		take && !hwrite && haddr[7:2] == OFFSET_CONTROL[7:2]
		|=> hrdata[5:0] == $past(hwdata[5:0], 3))
		else $error("control readback differs");
	a_count_readback: assert property (
		wr_q && ad_q[7:2] == OFFSET_COUNTER_VALUE[7:2] ##2
		take && !hwrite && haddr[7:2] == OFFSET_COUNTER_VALUE[7:2]
		|=> hrdata[7:0] == $past(hwdata[7:0], 3)
		|| hrdata[7:0] == $past(hwdata[7:0], 3) + 8'h01)
		else $error("counter readback differs");
endmodule : event_counter_checker
bind event_counter_top event_counter_checker event_counter_checker_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .irq(irq)
);
`default_nettype wire

//--- tb/pulse_source.sv
// Partner model: the external pulse source on the counter pin.
// Assumes the bench calls its tasks; levels change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module pulse_source (
	input  wire logic hclk,        // Bus clock, used only for pacing.
	output logic      counter_pin  // Pin level seen by the counter.
);
	initial counter_pin = 1'b0;
	// Moves the pin to a level and holds it for a number of cycles.
	task automatic hold_level(input logic level, input int cycles);
		@(posedge hclk);
		counter_pin <= level;
		repeat (cycles) @(posedge hclk);
	endtask : hold_level
	// Sends whole pulses; width of 4 keeps each level past the synchroniser.
	task automatic send_pulses(input int count, input int width);
		repeat (count) begin
			hold_level(1'b1, width);
			hold_level(1'b0, width);
		end
	endtask : send_pulses
endmodule : pulse_source
`default_nettype wire

//--- tb/tb_edge_or_cycle_event_counter.sv
// Testbench for the event counter: bus tasks, one task per scenario.
// Assumes event_counter_top, pulse_source and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_edge_or_cycle_event_counter
	import event_counter_pkg::*;
;
	logic        hclk       = 1'b0;         // Bus clock.
	logic        hresetn    = 1'b0;         // Reset, active low.
	logic        hsel       = 1'b0;         // Slave select.
	logic [31:0] haddr      = 32'h00000000; // Byte address.
	logic [1:0]  htrans     = 2'h0;         // Transfer type.
	logic        hwrite     = 1'b0;         // Write when high.
	logic [31:0] hwdata     = 32'h00000000; // Write data.
	logic        hready;                    // Ready fed back from the slave.
	logic        hresp;                     // Response.
	logic [31:0] hrdata;                    // Read data.
	logic        counter_pin;               // Pin from the pulse source.
	logic        irq;                       // Interrupt level.
	int          num_errors = 0;            // Mismatches seen.
	int          tests_run  = 0;            // Comparisons made.
	logic [31:0] got;                       // Last value read.
	// Clock of 4 ns.
	always #(CLOCK_PERIOD_NS / 2) hclk = ~hclk;
	event_counter_top event_counter_top_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .counter_pin(counter_pin),
		.irq(irq)
	);
	pulse_source pulse_source_i (.hclk(hclk), .counter_pin(counter_pin));
	// One single transfer; read data lands in got at the data edge.
	task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, addr};
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wdata;
		do @(posedge hclk); while (hready !== 1'b1);
		got = hrdata;
	endtask : bus_xfer
	// Writes one register.
	task automatic reg_write(input logic [7:0] addr, input logic [31:0] wdata);
		bus_xfer(1'b1, addr, wdata);
	endtask : reg_write
	// Counts a comparison and reports a mismatch.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	// Reads a register and compares it.
	task automatic expect_reg(input string what, input logic [7:0] addr, input logic [31:0] exp);
		bus_xfer(1'b0, addr, 32'h00000000);
		check(what, exp, got);
	endtask : expect_reg
	// Compares the interrupt once the last edge has settled.
	task automatic expect_irq(input logic exp);
		#1;
		check("irq", {31'h0, exp}, {31'h0, irq});
	endtask : expect_irq
	// Reset values and an unmapped offset.
	task automatic test_reset;
		expect_reg("control", OFFSET_CONTROL, 32'h00000000);
		expect_reg("status", OFFSET_IRQ_STATUS, 32'h00000000);
		expect_reg("enable", OFFSET_IRQ_ENABLE, 32'h00000000);
		expect_reg("unmapped", 8'h14, 32'h00000000);
		expect_irq(1'b0);
		$display("test reset done");
	endtask : test_reset
	// Cycle clock source, prescaler bypassed, pin toggling: one count per two clocks.
	task automatic test_cycle;
		reg_write(OFFSET_CONTROL, 32'h00000008);
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000000);
		pulse_source_i.send_pulses(5, 4);
		bus_xfer(1'b0, OFFSET_COUNTER_VALUE, 32'h00000000);
		check("cycle count", 32'h00000001, {31'h0, got == 32'h00000019 || got == 32'h0000001A});
		$display("test cycle done");
	endtask : test_cycle
	// Pin source with both edge selections.
	task automatic test_pin;
		reg_write(OFFSET_CONTROL, 32'h00000028);
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000000);
		pulse_source_i.hold_level(1'b1, 8);
		expect_reg("rising edge", OFFSET_COUNTER_VALUE, 32'h00000001);
		pulse_source_i.hold_level(1'b0, 8);
		expect_reg("falling ignored", OFFSET_COUNTER_VALUE, 32'h00000001);
		reg_write(OFFSET_CONTROL, 32'h00000038);
		expect_reg("control", OFFSET_CONTROL, 32'h00000038);
		pulse_source_i.hold_level(1'b1, 8);
		expect_reg("rising ignored", OFFSET_COUNTER_VALUE, 32'h00000001);
		pulse_source_i.hold_level(1'b0, 8);
		expect_reg("falling edge", OFFSET_COUNTER_VALUE, 32'h00000002);
		$display("test pin done");
	endtask : test_pin
	// Prescaler of 1:4 and its clearing by a counter write.
	task automatic test_prescaler;
		reg_write(OFFSET_CONTROL, 32'h00000021);
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000000);
		pulse_source_i.send_pulses(6, 4);
		expect_reg("divided count", OFFSET_COUNTER_VALUE, 32'h00000001);
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000000);
		pulse_source_i.send_pulses(2, 4);
		expect_reg("cleared prescaler", OFFSET_COUNTER_VALUE, 32'h00000000);
		pulse_source_i.send_pulses(2, 4);
		expect_reg("fourth event", OFFSET_COUNTER_VALUE, 32'h00000001);
		$display("test prescaler done");
	endtask : test_prescaler
	// Wrap from the top, sticky flag, masking and clearing.
	task automatic test_overflow;
		reg_write(OFFSET_CONTROL, 32'h00000028);
		reg_write(OFFSET_IRQ_CLEAR, 32'h00000001);
		reg_write(OFFSET_IRQ_ENABLE, 32'h00000001);
		reg_write(OFFSET_COUNTER_VALUE, 32'h000000FE);
		expect_reg("written count", OFFSET_COUNTER_VALUE, 32'h000000FE);
		pulse_source_i.send_pulses(1, 4);
		expect_reg("top count", OFFSET_COUNTER_VALUE, 32'h000000FF);
		expect_irq(1'b0);
		pulse_source_i.send_pulses(1, 4);
		expect_reg("wrapped count", OFFSET_COUNTER_VALUE, 32'h00000000);
		expect_reg("overflow flag", OFFSET_IRQ_STATUS, 32'h00000001);
		expect_irq(1'b1);
		reg_write(OFFSET_IRQ_STATUS, 32'h00000000);
		reg_write(OFFSET_IRQ_ENABLE, 32'h00000000);
		expect_irq(1'b0);
		expect_reg("masked flag", OFFSET_IRQ_STATUS, 32'h00000001);
		reg_write(OFFSET_IRQ_ENABLE, 32'h00000001);
		reg_write(OFFSET_IRQ_CLEAR, 32'h00000001);
		expect_reg("cleared flag", OFFSET_IRQ_STATUS, 32'h00000000);
		expect_irq(1'b0);
		$display("test overflow done");
	endtask : test_overflow
	// Prints the counts and the verdict, then stops.
	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	// Main sequence after 16 cycles of reset.
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset();
		test_cycle();
		test_pin();
		test_prescaler();
		test_overflow();
		wrap_up();
	end
	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		repeat (5000) @(posedge hclk);
		num_errors++;
		$display("unexpected end: expected tests done, seen timeout");
		wrap_up();
	end
endmodule : tb_edge_or_cycle_event_counter
`default_nettype wire
